/* quest_pkg.sv */
package quest_pkg;

  localparam int          REG_W           = 16;
  localparam int          MAX_CHAN        = 4;
  localparam logic [15:0] MASK_RESET      = 16'h0000;
  localparam logic [15:0] CHAN_MASK_RESET = 16'h7fff;
  localparam logic [15:0] RISE_RESET      = 16'h7fff;
  localparam logic [15:0] FALL_RESET      = 16'h0000;
  localparam int          BIT_HV          = 0;
  localparam int          BIT_HC          = 1;
  localparam int          BIT_LINE        = 2;
  localparam int          BIT_HEAT        = 4;
  localparam int          BIT_COMM        = 8;
  localparam int          BIT_LINKED      = 11;
  localparam int          BIT_ROLLUP      = 13;
  localparam logic [15:0] TRIP_USED       = 16'h2917;
  localparam logic [15:0] SUM_USED        = 16'h000f;

  typedef enum logic [1:0] {
    OP_NONE   = 2'b00,
    OP_READ   = 2'b01,
    OP_WRITE  = 2'b10,
    OP_PRESET = 2'b11
  } cmd_op_t;

  typedef enum logic [1:0] {
    LVL_TOP     = 2'b00,
    LVL_SUMMARY = 2'b01,
    LVL_CHANNEL = 2'b10
  } level_t;

  typedef enum logic [2:0] {
    FLD_EVENT = 3'b000,
    FLD_LIVE  = 3'b001,
    FLD_MASK  = 3'b010,
    FLD_RISE  = 3'b011,
    FLD_FALL  = 3'b100
  } field_t;

  typedef struct packed {
    cmd_op_t     op;
    level_t      level;
    field_t      field;
    logic [1:0]  chan;
    logic [15:0] data;
  } cmd_t;

  typedef struct packed {
    logic high_voltage_trip;
    logic high_current_trip;
    logic line_power_loss;
    logic heat_trip;
    logic comm_monitor_trip;
    logic linked_channel_trip;
  } trip_t;

  typedef struct packed {
    logic wr_mask;
    logic wr_rise;
    logic wr_fall;
    logic rd_clear;
  } level_ctl_t;

  typedef struct packed {
    logic [15:0] latched;
    logic [15:0] live;
    logic [15:0] mask;
    logic [15:0] rise;
    logic [15:0] fall;
  } level_view_t;

  typedef struct packed {
    logic [15:0] prev;
    logic [15:0] latched;
    logic [15:0] mask;
    logic [15:0] rise;
    logic [15:0] fall;
  } level_state_t;

  typedef struct packed {
    logic        valid;
    logic        err;
    logic [15:0] data;
  } rsp_t;

  typedef struct packed {
    rsp_t rsp;
    logic summary;
  } tree_state_t;

  // Trip inputs to a 16-bit live word; unused bits stay zero
  function automatic logic [15:0] pack_trips(trip_t t, logic rollup);
    logic [15:0] v;
    v             = 16'h0000;
    v[BIT_HV]     = t.high_voltage_trip;
    v[BIT_HC]     = t.high_current_trip;
    v[BIT_LINE]   = t.line_power_loss;
    v[BIT_HEAT]   = t.heat_trip;
    v[BIT_COMM]   = t.comm_monitor_trip;
    v[BIT_LINKED] = t.linked_channel_trip;
    v[BIT_ROLLUP] = rollup;
    return v;
  endfunction : pack_trips

  // One field of a level's view, for the read answer
  function automatic logic [15:0] pick_field(level_view_t v, field_t f);
    case (f)
      FLD_EVENT: return v.latched;
      FLD_LIVE:  return v.live;
      FLD_MASK:  return v.mask;
      FLD_RISE:  return v.rise;
      FLD_FALL:  return v.fall;
      default:   return 16'h0000;
    endcase
  endfunction : pick_field

endpackage : quest_pkg

/* status_level.sv */
`timescale 1ns/1ps
module status_level #(
  parameter logic [15:0] USED     = 16'hffff,
  parameter logic [15:0] MASK_DEF = 16'h0000
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire logic [15:0]            i_live,
  input  wire quest_pkg::level_ctl_t  i_ctl,
  input  wire logic                   i_preset,
  input  wire logic [15:0]            i_wdata,
  output quest_pkg::level_view_t      o_view,
  output logic                        o_summary
);
  import quest_pkg::*;

  level_state_t s_reg;
  level_state_t s_next;
  logic [15:0]  live;
  logic [15:0]  rise_hits;
  logic [15:0]  fall_hits;

  ////////////////////////////////////////////////////////////////////////
  // Next state: edge filters, clear-on-read, writes, preset
  always_comb begin
    s_next    = s_reg;
    live      = i_live & USED;
    rise_hits = live & ~s_reg.prev & s_reg.rise;
    fall_hits = ~live & s_reg.prev & s_reg.fall;
    s_next.prev = live;
    // New hits win over the clear of the same cycle
    s_next.latched = ((s_reg.latched & ~{16{i_ctl.rd_clear}})
                      | rise_hits | fall_hits) & USED;
    if (i_ctl.wr_mask) begin
      s_next.mask = i_wdata;
    end
    if (i_ctl.wr_rise) begin
      s_next.rise = i_wdata;
    end
    if (i_ctl.wr_fall) begin
      s_next.fall = i_wdata;
    end
    // Preset leaves latched events and history alone
    if (i_preset) begin
      s_next.mask = MASK_DEF;
      s_next.rise = RISE_RESET;
      s_next.fall = FALL_RESET;
    end
  end

  // Reset matches the preset defaults
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '{prev: 16'h0000, latched: 16'h0000, mask: MASK_DEF,
                 rise: RISE_RESET, fall: FALL_RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  // Views and summary; live view is a pure read
  assign o_view    = '{latched: s_reg.latched, live: live,
                       mask: s_reg.mask, rise: s_reg.rise,
                       fall: s_reg.fall};
  assign o_summary = |(s_reg.latched & s_reg.mask);

endmodule : status_level

/* cmd_decode.sv */
`timescale 1ns/1ps
module cmd_decode #(
  parameter int NUM_CHAN = 4
) (
  input  wire quest_pkg::cmd_t        i_cmd,
  output quest_pkg::level_ctl_t       o_top_ctl,
  output quest_pkg::level_ctl_t       o_sum_ctl,
  output quest_pkg::level_ctl_t       o_chan_ctl [NUM_CHAN],
  output logic                        o_preset,
  output logic                        o_bad
);
  import quest_pkg::*;

  // Strobes for one level when the command addresses it
  function automatic level_ctl_t ctl_for(cmd_t c, logic hit);
    level_ctl_t k;
    k.wr_mask  = hit && c.op == OP_WRITE && c.field == FLD_MASK;
    k.wr_rise  = hit && c.op == OP_WRITE && c.field == FLD_RISE;
    k.wr_fall  = hit && c.op == OP_WRITE && c.field == FLD_FALL;
    k.rd_clear = hit && c.op == OP_READ && c.field == FLD_EVENT;
    return k;
  endfunction : ctl_for

  logic chan_ok;
  logic field_ok;
  logic level_ok;

  assign chan_ok  = int'(i_cmd.chan) < NUM_CHAN;
  assign field_ok = i_cmd.field inside {FLD_EVENT, FLD_LIVE, FLD_MASK,
                                        FLD_RISE, FLD_FALL};
  assign level_ok = i_cmd.level inside {LVL_TOP, LVL_SUMMARY}
                    || (i_cmd.level == LVL_CHANNEL && chan_ok);

  // Level strobes; a bad command touches nothing
  assign o_top_ctl = ctl_for(i_cmd, field_ok && i_cmd.level == LVL_TOP);
  assign o_sum_ctl = ctl_for(i_cmd,
                             field_ok && i_cmd.level == LVL_SUMMARY);
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    assign o_chan_ctl[g] = ctl_for(i_cmd, field_ok
                                   && i_cmd.level == LVL_CHANNEL
                                   && int'(i_cmd.chan) == g);
  end

  assign o_preset = i_cmd.op == OP_PRESET;
  // Event and live views cannot be written
  assign o_bad = (i_cmd.op == OP_READ || i_cmd.op == OP_WRITE)
                 && (!field_ok || !level_ok
                     || (i_cmd.op == OP_WRITE
                         && i_cmd.field inside {FLD_EVENT, FLD_LIVE}));

endmodule : cmd_decode

/* questionable_status_tree.sv */
`timescale 1ns/1ps
module questionable_status_tree #(
  parameter int NUM_CHAN = 4
) (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire quest_pkg::cmd_t        i_cmd,
  input  wire quest_pkg::trip_t       i_top_trips,
  input  wire quest_pkg::trip_t       i_chan_trips [NUM_CHAN],
  input  wire logic [NUM_CHAN-1:0]    i_chan_rollup,
  output quest_pkg::rsp_t             o_rsp,
  output logic                        o_ques_summary
);
  import quest_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Elaboration check: channel-summary holds at most four rollups
  if (NUM_CHAN < 1 || NUM_CHAN > MAX_CHAN) begin : g_bad_chan
    $error("NUM_CHAN must be 1 to 4");
  end

  level_ctl_t  top_ctl;
  level_ctl_t  sum_ctl;
  level_ctl_t  chan_ctl [NUM_CHAN];
  logic        preset;
  logic        bad;
  level_view_t top_view;
  level_view_t sum_view;
  level_view_t chan_view [NUM_CHAN];
  logic        top_summary;
  logic        sum_summary;
  logic [15:0] sum_live;
  logic [15:0] top_live;
  logic [NUM_CHAN-1:0] chan_summary;
  tree_state_t s_reg;
  tree_state_t s_next;

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  cmd_decode #(
    .NUM_CHAN (NUM_CHAN)
  ) u_decode (
    .i_cmd      (i_cmd),
    .o_top_ctl  (top_ctl),
    .o_sum_ctl  (sum_ctl),
    .o_chan_ctl (chan_ctl),
    .o_preset   (preset),
    .o_bad      (bad)
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-channel levels; linked trip comes from outside shutdown logic
  for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
    status_level #(
      .USED     (TRIP_USED),
      .MASK_DEF (CHAN_MASK_RESET)
    ) u_chan (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_live    (pack_trips(i_chan_trips[g],
                             i_chan_rollup[g])),
      .i_ctl     (chan_ctl[g]),
      .i_preset  (preset),
      .i_wdata   (i_cmd.data),
      .o_view    (chan_view[g]),
      .o_summary (chan_summary[g])
    );
  end

  // Channel rollups land in bits 0 to NUM_CHAN-1
  always_comb begin
    sum_live = 16'h0000;
    sum_live[NUM_CHAN-1:0] = chan_summary;
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel-summary level
  status_level #(
    .USED     (SUM_USED),
    .MASK_DEF (MASK_RESET)
  ) u_sum (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_live    (sum_live),
    .i_ctl     (sum_ctl),
    .i_preset  (preset),
    .i_wdata   (i_cmd.data),
    .o_view    (sum_view),
    .o_summary (sum_summary)
  );

  // Top live word; bit 13 is the channel-summary rollup
  assign top_live = pack_trips(i_top_trips, sum_summary);

  ////////////////////////////////////////////////////////////////////////
  // Top questionable level
  status_level #(
    .USED     (TRIP_USED),
    .MASK_DEF (MASK_RESET)
  ) u_top (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_live    (top_live),
    .i_ctl     (top_ctl),
    .i_preset  (preset),
    .i_wdata   (i_cmd.data),
    .o_view    (top_view),
    .o_summary (top_summary)
  );

  ////////////////////////////////////////////////////////////////////////
  // Answer: reads return data taken before the clear lands
  always_comb begin
    s_next         = s_reg;
    s_next.summary = top_summary;
    s_next.rsp     = '{valid: 1'b0, err: 1'b0, data: 16'h0000};
    if (i_cmd.op != OP_NONE) begin
      s_next.rsp.valid = 1'b1;
      s_next.rsp.err   = bad;
    end
    if (i_cmd.op == OP_READ && !bad) begin
      case (i_cmd.level)
        LVL_TOP: begin
          s_next.rsp.data = pick_field(top_view, i_cmd.field);
        end
        LVL_SUMMARY: begin
          s_next.rsp.data = pick_field(sum_view, i_cmd.field);
        end
        LVL_CHANNEL: begin
          // Index is range-checked by the decoder
          for (int c = 0; c < NUM_CHAN; c++) begin
            if (int'(i_cmd.chan) == c) begin
              s_next.rsp.data = pick_field(chan_view[c],
                                           i_cmd.field);
            end
          end
        end
        default: begin
          s_next.rsp.data = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s_reg <= '{rsp: '{valid: 1'b0, err: 1'b0, data: 16'h0000},
                 summary: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_rsp          = s_reg.rsp;
  assign o_ques_summary = s_reg.summary;

endmodule : questionable_status_tree

/* questionable_status_tree_monitor.sv */
`timescale 1ns/1ps
module questionable_status_tree_monitor
  import quest_pkg::*;
#(
  parameter int NUM_CHAN = 4
) (
  input wire logic                i_sys_clk,
  input wire logic                i_rst,
  input wire quest_pkg::cmd_t     i_cmd,
  input wire quest_pkg::trip_t    i_top_trips,
  input wire quest_pkg::trip_t    i_chan_trips [NUM_CHAN],
  input wire logic [NUM_CHAN-1:0] i_chan_rollup,
  input wire quest_pkg::rsp_t     o_rsp,
  input wire logic                o_ques_summary
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  //////////////////////////////////////////////////////////////////////////
  // Command decode helpers, stat covers the event and live views; only the event view clears on read
  logic rd;
  logic wr;
  logic stat;
  assign rd   = i_cmd.op == OP_READ;
  assign wr   = i_cmd.op == OP_WRITE;
  assign stat = i_cmd.field inside {FLD_EVENT, FLD_LIVE};

  //////////////////////////////////////////////////////////////////////////
  // Every command answers exactly one cycle later, never otherwise
  AST_ANSWER: assert property (i_cmd.op != OP_NONE |=> o_rsp.valid)
    else $error("command got no answer");
  AST_QUIET: assert property (i_cmd.op == OP_NONE |=> !o_rsp.valid)
    else $error("answer without command");
  AST_WR_NODATA: assert property (wr |=> o_rsp.data == 16'h0000)
    else $error("write answered with data");
  AST_WR_STAT_ERR: assert property (wr && stat |=> o_rsp.err)
    else $error("write to status view accepted");
  AST_PRESET_OK: assert property (i_cmd.op == OP_PRESET |=>
    o_rsp.valid && !o_rsp.err)
    else $error("preset refused");
  AST_BAD_CHAN: assert property ((rd || wr) && i_cmd.level == LVL_CHANNEL &&
    i_cmd.chan >= NUM_CHAN |=> o_rsp.err)
    else $error("missing channel accepted");
  AST_BIT15: assert property (rd && stat |=> !o_rsp.data[15])
    else $error("status bit 15 set");
  AST_SUM_UNUSED: assert property (rd && stat && i_cmd.level == LVL_SUMMARY
    |=> (o_rsp.data & ~SUM_USED) == 16'h0000)
    else $error("unused summary bit set");
  AST_CHAN_UNUSED: assert property (rd && stat && i_cmd.level == LVL_CHANNEL
    |=> (o_rsp.data & ~TRIP_USED) == 16'h0000)
    else $error("unused channel bit set");
  // Preset clears the top mask, so the summary must drop two edges on
  AST_PRESET_SUM: assert property (i_cmd.op == OP_PRESET |->
    ##2 !o_ques_summary)
    else $error("summary high after preset");

  COV_PRESET: cover property (i_cmd.op == OP_PRESET);
  COV_ERR:    cover property (o_rsp.valid && o_rsp.err);
  COV_SUM:    cover property ($rose(o_ques_summary));
endmodule : questionable_status_tree_monitor

bind questionable_status_tree questionable_status_tree_monitor #(
  .NUM_CHAN(NUM_CHAN)
) i_mon (
  .i_sys_clk      (i_sys_clk),
  .i_rst          (i_rst),
  .i_cmd          (i_cmd),
  .i_top_trips    (i_top_trips),
  .i_chan_trips   (i_chan_trips),
  .i_chan_rollup  (i_chan_rollup),
  .o_rsp          (o_rsp),
  .o_ques_summary (o_ques_summary)
);

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import quest_pkg::*;
  // Three channels, so index 3 exercises the refusal path
  localparam int NC = 3;
  logic          i_sys_clk = 1'b0;
  logic          i_rst     = 1'b1;
  cmd_t          i_cmd;
  trip_t         i_top_trips;
  trip_t         i_chan_trips [NC];
  logic [NC-1:0] i_chan_rollup;
  rsp_t          o_rsp;
  logic          o_ques_summary;
  rsp_t          r;
  int            err_count = 0;
  int            n_checks  = 0;
  int            cyc       = 0;
  logic [15:0]   vals [3]  = '{16'hffff, 16'h0000, 16'ha5c3};

  questionable_status_tree #(.NUM_CHAN(NC)) i_dut (
    .i_sys_clk      (i_sys_clk),
    .i_rst          (i_rst),
    .i_cmd          (i_cmd),
    .i_top_trips    (i_top_trips),
    .i_chan_trips   (i_chan_trips),
    .i_chan_rollup  (i_chan_rollup),
    .o_rsp          (o_rsp),
    .o_ques_summary (o_ques_summary)
  );

  // 50 ns clock
  always #25 i_sys_clk = ~i_sys_clk;

  //////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  // Hang guard, the whole run needs well under 1000 cycles
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One command, taken at the next edge; answer sampled just after it.
  // A quiet cycle follows, so the next call never rewrites the command
  // in the same time step that this one dropped it.
  task automatic acc(cmd_op_t op, level_t lv, field_t f, logic [1:0] ch,
                     logic [15:0] d);
    i_cmd = '{op, lv, f, ch, d};
    @(posedge i_sys_clk);
    #1;
    r = o_rsp;
    i_cmd.op = OP_NONE;
    @(posedge i_sys_clk);
    #1;
  endtask : acc

  task automatic rd(level_t lv, field_t f, logic [1:0] ch, logic [15:0] exp,
                    string what);
    acc(OP_READ, lv, f, ch, 16'h0000);
    chk(what, r.data, exp);
    chk({what, " ans"}, {14'h0, r.valid, r.err}, 16'h0002);
  endtask : rd

  task automatic idle(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : idle

  // Masks and filters of every level against their default values
  task automatic defaults();
    for (int l = 0; l < 3; l++) begin
      for (int c = 0; c < ((l == 2) ? NC : 1); c++) begin
        rd(level_t'(l), FLD_MASK, 2'(c),
           (l == 2) ? CHAN_MASK_RESET : MASK_RESET, "mask");
        rd(level_t'(l), FLD_RISE, 2'(c), RISE_RESET, "rise");
        rd(level_t'(l), FLD_FALL, 2'(c), FALL_RESET, "fall");
      end
    end
  endtask : defaults

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    i_cmd         = '0;
    i_top_trips   = '0;
    i_chan_trips  = '{default: '0};
    i_chan_rollup = '0;
    repeat (20) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    defaults();
    foreach (vals[i]) begin
      for (int l = 0; l < 3; l++) begin
        for (int f = 2; f < 5; f++) begin
          acc(OP_WRITE, level_t'(l), field_t'(f), 2'd1, vals[i]);
          rd(level_t'(l), field_t'(f), 2'd1, vals[i], "rdbk");
        end
      end
    end
    acc(OP_PRESET, LVL_TOP, FLD_EVENT, 2'd0, 16'h0000);
    defaults();
    // Full trip set on channel 2 climbs the tree
    i_chan_trips[2] = '1;
    i_chan_rollup   = 3'b100;
    idle(3);
    rd(LVL_CHANNEL, FLD_LIVE, 2'd2, 16'h2917, "ch2 live");
    rd(LVL_CHANNEL, FLD_LIVE, 2'd2, 16'h2917, "ch2 live2");
    rd(LVL_CHANNEL, FLD_LIVE, 2'd0, 16'h0000, "ch0 live");
    rd(LVL_SUMMARY, FLD_LIVE, 2'd0, 16'h0004, "sum live");
    acc(OP_WRITE, LVL_SUMMARY, FLD_MASK, 2'd0, 16'hffff);
    idle(3);
    rd(LVL_TOP, FLD_LIVE, 2'd0, 16'h2000, "top live");
    chk("sum masked", {15'h0, o_ques_summary}, 16'h0000);
    acc(OP_WRITE, LVL_TOP, FLD_MASK, 2'd0, 16'h2000);
    idle(2);
    chk("sum on", {15'h0, o_ques_summary}, 16'h0001);
    rd(LVL_TOP, FLD_EVENT, 2'd0, 16'h2000, "top ev");
    rd(LVL_TOP, FLD_EVENT, 2'd0, 16'h0000, "top ev clr");
    idle(2);
    chk("sum off", {15'h0, o_ques_summary}, 16'h0000);
    acc(OP_PRESET, LVL_TOP, FLD_EVENT, 2'd0, 16'h0000);
    rd(LVL_CHANNEL, FLD_EVENT, 2'd2, 16'h2917, "ch2 ev kept");
    rd(LVL_CHANNEL, FLD_EVENT, 2'd2, 16'h0000, "ch2 ev clr");
    // Falling edge only, on channel 1
    acc(OP_WRITE, LVL_CHANNEL, FLD_RISE, 2'd1, 16'h0000);
    acc(OP_WRITE, LVL_CHANNEL, FLD_FALL, 2'd1, 16'h0001);
    i_chan_trips[1].high_voltage_trip = 1'b1;
    idle(2);
    rd(LVL_CHANNEL, FLD_EVENT, 2'd1, 16'h0000, "rise blocked");
    i_chan_trips[1].high_voltage_trip = 1'b0;
    idle(2);
    rd(LVL_CHANNEL, FLD_EVENT, 2'd1, 16'h0001, "fall caught");
    // Top trip inputs land on their own bits; bit 13 stays masked off
    i_top_trips = '1;
    rd(LVL_TOP, FLD_LIVE, 2'd0, 16'h0917, "top trips");
    // Refused commands
    acc(OP_WRITE, LVL_TOP, FLD_EVENT, 2'd0, 16'h1234);
    chk("wr ev err", {15'h0, r.err}, 16'h0001);
    acc(OP_READ, LVL_CHANNEL, FLD_LIVE, 2'd3, 16'h0000);
    chk("chan err", {15'h0, r.err}, 16'h0001);
    final_report();
  end
endmodule : tb
